// ==== rtl/ark_top.sv ====
// audio routing, soft-stepped gain control and keyclick register
`timescale 1ns/1ps
module ark_top
  import ark_pkg::*;
#(
  parameter int KC_HALF_8K = ARK_KC_HALF_8K
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_page,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic fsref_tick,
  input wire logic adc_pwr,
  input wire logic dac_pwr,
  input wire logic [6:0] phone_gain_set,
  input wire logic [6:0] mic_gain_set,
  input wire logic [3:0] buzz_gain_set,
  input wire logic [6:0] mix_vol_set,
  input wire logic mix_mute_set,
  input wire logic mix_en_set,
  input wire logic phone_to_rec_set,
  input wire logic phone_out_dac_set,
  input wire logic [1:0] adc_src_set,
  output logic [6:0] phone_gain,
  output logic [6:0] mic_gain,
  output logic [3:0] buzz_gain,
  output logic [6:0] mix_vol,
  output logic mix_mute,
  output logic mix_to_dac,
  output logic phone_to_rec,
  output logic phone_out_dac,
  output logic gain_busy,
  output logic kc_wave,
  output logic [2:0] kc_amp,
  output logic kc_active
);
  ark_click_if kc ();

  logic [15:0] kc_reg_q;
  logic kc_hit;
  logic [6:0] osc_cnt_q;
  logic osc_tick;
  logic pga_tick;
  logic mix_tick;
  logic mix_avail;
  logic phone_mv;
  logic mic_mv;
  logic buzz_mv;
  logic mix_mv;
  logic mix_mute_q;
  logic mix_to_dac_q;
  logic phone_to_rec_q;
  logic phone_out_dac_q;
  logic kc_wave_q;
  logic [2:0] kc_amp_q;
  ark_adc_src_t adc_src;

  assign kc_hit = (reg_page == ARK_KC_PAGE) && (reg_addr == ARK_KC_ADDR);

  // keyclick register: fields stored, enable reads back the live busy flag
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      kc_reg_q <= ARK_KC_RESET;
    end
    else if (reg_wr && kc_hit)
    begin
      kc_reg_q <= reg_wdata;
    end
  end

  // any write starts or restarts the click; start wins over self-clear
  assign kc.start = reg_wr && kc_hit;
  assign kc.amp = reg_wdata[ARK_KC_AMP_LSB +: 3];
  assign kc.freq = reg_wdata[ARK_KC_FRQ_LSB +: 3];
  assign kc.len = reg_wdata[ARK_KC_LEN_LSB +: 4];

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        if (kc_hit)
        begin
          reg_rdata <= {kc.busy, kc_reg_q[14:0]};
        end
        else
        begin
          reg_rdata <= 16'h0000;
        end
      end
    end
  end

  // internal oscillator tick, always running regardless of converter power
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_cnt_q <= 7'h00;
    end
    else if (osc_tick)
    begin
      osc_cnt_q <= 7'h00;
    end
    else
    begin
      osc_cnt_q <= osc_cnt_q + 7'h01;
    end
  end

  assign osc_tick = (osc_cnt_q == 7'(ARK_OSC_DIV - 1));
  assign pga_tick = dac_pwr ? fsref_tick : osc_tick;
  assign mix_tick = (adc_pwr || dac_pwr) ? fsref_tick : osc_tick;

  ark_stepper #(
    .W(7),
    .MAXC(ARK_HALF_DB_MAX)
  ) u_phone (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(pga_tick),
    .target(phone_gain_set),
    .cur_q(phone_gain),
    .moving(phone_mv)
  );

  ark_stepper #(
    .W(7),
    .MAXC(ARK_HALF_DB_MAX)
  ) u_mic (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(pga_tick),
    .target(mic_gain_set),
    .cur_q(mic_gain),
    .moving(mic_mv)
  );

  ark_stepper #(
    .W(4),
    .MAXC(ARK_BUZZ_MAX)
  ) u_buzz (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(pga_tick),
    .target(buzz_gain_set),
    .cur_q(buzz_gain),
    .moving(buzz_mv)
  );

  ark_stepper #(
    .W(7),
    .MAXC(ARK_HALF_DB_MAX)
  ) u_mix (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(mix_tick),
    .target(mix_vol_set),
    .cur_q(mix_vol),
    .moving(mix_mv)
  );

  assign gain_busy = phone_mv || mic_mv || buzz_mv || mix_mv;

  assign adc_src = ark_adc_src_t'(adc_src_set);
  assign mix_avail = (adc_src == ARK_SRC_MIC_SE) ||
    (adc_src == ARK_SRC_AUX);

  // routing switches hold no dependency on converter power
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mix_mute_q <= 1'b1;
      mix_to_dac_q <= 1'b0;
      phone_to_rec_q <= 1'b0;
      phone_out_dac_q <= 1'b0;
    end
    else
    begin
      mix_mute_q <= mix_mute_set;
      mix_to_dac_q <= mix_en_set && mix_avail;
      phone_to_rec_q <= phone_to_rec_set;
      phone_out_dac_q <= phone_out_dac_set;
    end
  end

  assign mix_mute = mix_mute_q;
  assign mix_to_dac = mix_to_dac_q;
  assign phone_to_rec = phone_to_rec_q;
  assign phone_out_dac = phone_out_dac_q;

  ark_keyclick #(
    .HALF_8K(KC_HALF_8K)
  ) u_click (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .kc(kc.gen)
  );

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      kc_wave_q <= 1'b0;
      kc_amp_q <= 3'h0;
    end
    else
    begin
      kc_wave_q <= kc.wave;
      if (kc.start)
      begin
        kc_amp_q <= kc.amp;
      end
    end
  end

  assign kc_wave = kc_wave_q;
  assign kc_amp = kc_amp_q;
  assign kc_active = kc.busy;
endmodule // ark_top

// ==== rtl/ark_pkg.sv ====
// constants, field layouts and step codes for audio routing and keyclick
// What this block does
// - phone input gain +12 to -34.5 dB
// - buzzer gain 0 to -45 dB, 3 dB
// - phone input may mix with microphone
// - phone output takes microphone or playback audio
// - routing works with both converters powered down
// - gains step on fsref or internal oscillator
// - mixer feeds record input into playback output
// - mixer only for single-ended mic or aux
// - mixer volume 0.5 dB steps, mute, soft-steps
// - mixer steps on oscillator when converters off
// - keyclick register holds amplitude, frequency, length
// - keyclick frequency 62.5 Hz to 8 kHz
// - keyclick length 2 to 32 periods
// - every keyclick write starts the square wave
// - enable bit clears itself after last period
// - keyclick works with converters powered down
package ark_pkg;
  localparam int ARK_CLK_HZ = 40_000_000;
  localparam int ARK_KC_FMAX_HZ = 8000;
  localparam int ARK_KC_HALF_8K = ARK_CLK_HZ / (2 * ARK_KC_FMAX_HZ);
  localparam int ARK_OSC_TICK_NS = 1000;
  localparam int ARK_CLK_NS = 25;
  localparam int ARK_OSC_DIV = ARK_OSC_TICK_NS / ARK_CLK_NS;
  localparam logic [3:0] ARK_KC_PAGE = 4'h2;
  localparam logic [5:0] ARK_KC_ADDR = 6'h04;
  localparam int ARK_KC_EN_BIT = 15;
  localparam int ARK_KC_AMP_LSB = 12;
  localparam int ARK_KC_FRQ_LSB = 8;
  localparam int ARK_KC_LEN_LSB = 4;
  localparam logic [15:0] ARK_KC_RESET = 16'h0000;
  localparam logic [6:0] ARK_HALF_DB_MAX = 7'h5d;
  localparam logic [3:0] ARK_BUZZ_MAX = 4'hf;
  localparam int ARK_CNT_W = 19;
  typedef enum logic [1:0] {ARK_SRC_MIC_SE, ARK_SRC_AUX, ARK_SRC_DIFF,
    ARK_SRC_RSVD} ark_adc_src_t;
endpackage

// ==== rtl/ark_click_if.sv ====
// handshake and settings between register file and keyclick generator
`timescale 1ns/1ps
interface ark_click_if;
  logic start;
  logic [2:0] amp;
  logic [2:0] freq;
  logic [3:0] len;
  logic busy;
  logic wave;
  modport ctrl (output start, output amp, output freq, output len,
    input busy, input wave);
  modport gen (input start, input amp, input freq, input len,
    output busy, output wave);
endinterface

// ==== rtl/ark_stepper.sv ====
// one soft-stepped gain stage: moves one code per tick toward its target
`timescale 1ns/1ps
module ark_stepper #(
  parameter int W = 7,
  parameter logic [W-1:0] MAXC = '1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic [W-1:0] target,
  output logic [W-1:0] cur_q,
  output logic moving
);
  logic [W-1:0] goal;

  assign goal = (target > MAXC) ? MAXC : target;
  assign moving = (cur_q != goal);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_q <= '0;
    end
    else if (tick && moving)
    begin
      if (cur_q < goal)
      begin
        cur_q <= cur_q + W'(1);
      end
      else
      begin
        cur_q <= cur_q - W'(1);
      end
    end
  end
endmodule // ark_stepper

// ==== rtl/ark_keyclick.sv ====
// keyclick square-wave generator with self-ending length count
`timescale 1ns/1ps
module ark_keyclick
  import ark_pkg::*;
#(
  parameter int HALF_8K = ARK_KC_HALF_8K
) (
  input wire logic ref_clk,
  input wire logic rstn,
  ark_click_if.gen kc
);
  logic [ARK_CNT_W-1:0] cnt_q;
  logic [ARK_CNT_W-1:0] half_len;
  logic [6:0] halves_q;
  logic [2:0] freq_q;
  logic [2:0] freq_sel;

  // write data moves on after the strobe, so reloads use the held code
  assign freq_sel = kc.start ? kc.freq : freq_q;

  // half period doubles per frequency code: 8 kHz down to 62.5 Hz
  assign half_len = ARK_CNT_W'(HALF_8K) << freq_sel;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= '0;
      halves_q <= '0;
      freq_q <= 3'h0;
      kc.busy <= 1'b0;
      kc.wave <= 1'b0;
    end
    else if (kc.start)
    begin
      cnt_q <= half_len - ARK_CNT_W'(1);
      freq_q <= kc.freq;
      halves_q <= {kc.len, 2'b00} + 7'h03;
      kc.busy <= 1'b1;
      kc.wave <= 1'b1;
    end
    else if (kc.busy)
    begin
      if (cnt_q == '0)
      begin
        cnt_q <= half_len - ARK_CNT_W'(1);
        kc.wave <= ~kc.wave;
        halves_q <= halves_q - 7'h01;
        if (halves_q == '0)
        begin
          kc.busy <= 1'b0;
          kc.wave <= 1'b0;
        end
      end
      else
      begin
        cnt_q <= cnt_q - ARK_CNT_W'(1);
      end
    end
  end
endmodule // ark_keyclick

// ==== verif/ark_top_asserts.sv ====
// concurrent checks on the audio routing and keyclick top ports
`timescale 1ns/1ps
module ark_top_asserts
  import ark_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_page,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic fsref_tick,
  input wire logic dac_pwr,
  input wire logic mix_en_set,
  input wire logic [1:0] adc_src_set,
  input wire logic [6:0] phone_gain,
  input wire logic [3:0] buzz_gain,
  input wire logic mix_to_dac,
  input wire logic [2:0] kc_amp,
  input wire logic kc_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic sel = reg_page == ARK_KC_PAGE && reg_addr == ARK_KC_ADDR;
  sequence s_hit;
    reg_wr && sel;
  endsequence
  a_rd_valid: assert property (reg_rd |=> reg_rvalid)
    else $error("read without valid");
  a_rd_unmapped: assert property (reg_rd && !sel |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  a_rd_busy: assert property (reg_rd && sel |=>
    reg_rdata[15] == $past(kc_active)) else $error("busy bit wrong");
  a_wr_start: assert property (s_hit |=> kc_active)
    else $error("write did not start click");
  a_amp_latch: assert property (s_hit |=>
    kc_amp == $past(reg_wdata[14:12])) else $error("amp not latched");
  a_click_min: assert property ($rose(kc_active) |-> kc_active[*8])
    else $error("click too short");
  a_mix_route: assert property ($past(rstn) |-> mix_to_dac ==
    $past(mix_en_set && !adc_src_set[1])) else $error("mixer route");
  a_step_tick: assert property ($past(dac_pwr) &&
    !$past(fsref_tick) |-> $stable(phone_gain))
    else $error("gain moved without tick");
  a_step_unit: assert property ($changed(buzz_gain) |->
    buzz_gain == $past(buzz_gain) + 4'h1 ||
    buzz_gain == $past(buzz_gain) - 4'h1) else $error("gain jumped");
endmodule // ark_top_asserts
bind ark_top ark_top_asserts ark_top_asserts_inst (.*);

// ==== verif/test_ark_top.sv ====
// self-checking bench for the audio routing and keyclick block
`timescale 1ns/1ps
module test_ark_top;
  import ark_pkg::*;
  logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, fsref_tick = 0;
  logic adc_pwr = 0, dac_pwr = 1, mix_mute_set = 0, mix_en_set = 0;
  logic phone_to_rec_set = 0, phone_out_dac_set = 0;
  logic [3:0] reg_page = 0, buzz_gain_set = 0, buzz_gain;
  logic [5:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, d;
  logic [6:0] phone_gain_set = 0, mic_gain_set = 0, mix_vol_set = 0;
  logic [6:0] phone_gain, mic_gain, mix_vol;
  logic [1:0] adc_src_set = 0;
  logic reg_rvalid, mix_mute, mix_to_dac, phone_to_rec, phone_out_dac;
  logic gain_busy, kc_wave, kc_active;
  logic [2:0] kc_amp;
  int fail_count = 0, n_compared = 0, cyc = 0;
  ark_top #(.KC_HALF_8K(4)) ark_top_inst (.*);
  initial
    forever #12.5 ref_clk = ~ref_clk;
  task results();
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      fail_count++;
      results();
    end
  end
  task chk(string n, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(logic [5:0] a, logic [15:0] v);
    reg_page = 4'h2;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  task rd(logic [5:0] a, output logic [15:0] v);
    reg_page = 4'h2;
    reg_addr = a;
    reg_rd = 1;
    @(negedge ref_clk);
    reg_rd = 0;
    chk("rvalid", 1, reg_rvalid);
    v = reg_rdata;
  endtask
  task click(logic [15:0] v);
    int c, w, n;
    logic pw;
    n = 4 * (int'(v[7:4]) + 1) * (4 << v[10:8]);
    wr(6'h04, v);
    chk("amp", v[14:12], kc_amp);
    rd(6'h04, d);
    chk("busy rd", {1'b1, v[14:0]}, d);
    reg_wdata = ~v;
    c = 1;
    w = 0;
    pw = 0;
    while (kc_active === 1'b1 && c < 40000)
    begin
      if (kc_wave === 1'b1 && !pw)
        w++;
      pw = kc_wave;
      c++;
      @(negedge ref_clk);
    end
    chk("length", 16'(n), 16'(c));
    chk("periods", 16'(2 * (int'(v[7:4]) + 1)), 16'(w));
    chk("wave end", 0, kc_wave);
    rd(6'h04, d);
    chk("idle rd", {1'b0, v[14:0]}, d);
  endtask
  task pulse();
    fsref_tick = 1;
    @(negedge ref_clk);
    fsref_tick = 0;
    repeat (2) @(negedge ref_clk);
  endtask
  initial
  begin
    repeat (3) @(negedge ref_clk);
    chk("reset mute", 1, mix_mute);
    rstn = 1;
    rd(6'h04, d);
    chk("reset val", ARK_KC_RESET, d);
    @(negedge ref_clk);
    rd(6'h05, d);
    chk("unmapped", 0, d);
    wr(6'h05, 16'h7ff0);
    chk("ignored", 0, kc_active);
    @(negedge ref_clk);
    for (int i = 0; i < 8; i++)
      click({1'b0, 3'(i), 1'b0, 3'(i), 4'((i * 5) % 16), 4'ha});
    wr(6'h04, 16'h8f70);
    repeat (5) @(negedge ref_clk);
    click(16'hd105);
    phone_gain_set = 7'h03;
    buzz_gain_set = 4'h2;
    repeat (6) @(negedge ref_clk);
    chk("no tick", 0, phone_gain);
    chk("moving", 1, gain_busy);
    repeat (2) pulse();
    chk("phone", 2, phone_gain);
    chk("buzz", 2, buzz_gain);
    pulse();
    chk("phone", 3, phone_gain);
    dac_pwr = 0;
    phone_gain_set = 0;
    mic_gain_set = ARK_HALF_DB_MAX;
    mix_vol_set = 7'h7f;
    buzz_gain_set = ARK_BUZZ_MAX;
    repeat (4200) @(negedge ref_clk);
    chk("mix vol", ARK_HALF_DB_MAX, mix_vol);
    chk("mic", ARK_HALF_DB_MAX, mic_gain);
    chk("phone", 0, phone_gain);
    chk("buzz", ARK_BUZZ_MAX, buzz_gain);
    chk("busy", 0, gain_busy);
    adc_pwr = 1;
    mix_vol_set = 7'h00;
    repeat (100) @(negedge ref_clk);
    chk("mix hold", ARK_HALF_DB_MAX, mix_vol);
    pulse();
    chk("mix step", ARK_HALF_DB_MAX - 7'h01, mix_vol);
    adc_pwr = 0;
    for (int s = 0; s < 4; s++)
    begin
      adc_src_set = 2'(s);
      mix_en_set = 1;
      phone_out_dac_set = s[0];
      phone_to_rec_set = s[1];
      mix_mute_set = s[0];
      repeat (2) @(negedge ref_clk);
      chk("mixer", s < 2, mix_to_dac);
      chk("out src", s[0], phone_out_dac);
      chk("to rec", s[1], phone_to_rec);
      chk("mute", s[0], mix_mute);
    end
    click(16'h3012);
    results();
  end
endmodule // test_ark_top
